/* File: dv/tb_tofms_top.sv */
// Self-checking bench for the operating-mode select block
`timescale 1ns/10ps
module tb_tofms_top;
   logic clock_i, rstn_i, reg_wr_i, reg_rd_i, exposure_trigger_i, pix_valid_i, pix_ready_o;
   logic pix_sat_i, pix_ovf_i, pix_unf_i, busy_o, frame_done_o, out_valid_o, out_ready_i;
   logic src_clr, stall, raw_md;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, out_data_o, flag_k;
   logic [2:0] mode_i;
   logic [11:0] pix_data_i;
   int failures, n_checks, cyc, n_done;
   logic [7:0] got[$];
   tofms_top u_dut (.clock_i, .rstn_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
      .reg_rdata_o, .mode_i, .exposure_trigger_i, .pix_valid_i, .pix_ready_o, .pix_data_i,
      .pix_sat_i, .pix_ovf_i, .pix_unf_i, .busy_o, .frame_done_o, .out_valid_o,
      .out_ready_i, .out_data_o);
   tofms_pixel_src u_src (.clock_i, .rstn_i, .clr_i(src_clr), .flag_k_i(flag_k),
      .pix_ready_i(pix_ready_o), .pix_valid_o(pix_valid_i), .pix_data_o(pix_data_i),
      .pix_sat_o(pix_sat_i), .pix_ovf_o(pix_ovf_i), .pix_unf_o(pix_unf_i));
   initial begin
      clock_i = 0;
      forever #4 clock_i = ~clock_i;
   end
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (out_valid_o && out_ready_i)
         got.push_back(out_data_o);
      if (frame_done_o)
         n_done++;
      if (cyc == 20000) begin
         failures++;
         conclude();
      end
   end
   // Sink also stalls every third cycle
   always @(negedge clock_i)
      out_ready_i <= !stall && (cyc % 3 != 0);
   task automatic conclude();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   // Sample carries a validity flag that the block must embed unless raw_md selects raw readout
   function automatic logic bad(input int k);
      return !raw_md && (k == flag_k || k == flag_k + 1 || k == flag_k + 5);
   endfunction
   function automatic logic [11:0] v(input int k);
      if (raw_md)
         return 12'(37 * k + 5);
      if (k == flag_k)
         return 12'h7ff;
      if (k == flag_k + 1)
         return 12'h7fe;
      if (k == flag_k + 5)
         return 12'h800;
      return 12'(37 * k + 5);
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock_i);
      reg_wr_i = 1;
      reg_addr_i = a;
      reg_wdata_i = d;
      @(negedge clock_i);
      reg_wr_i = 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_rd_i = 1;
      reg_addr_i = a;
      @(negedge clock_i);
      reg_rd_i = 0;
      @(negedge clock_i);
      chk("reg", {16'h0000, e}, {16'h0000, reg_rdata_o});
   endtask
   task automatic run(input logic [2:0] m, input logic [7:0] md, input int nb, input int nd,
      input logic st);
      int t;
      wr(8'h12, md);
      got.delete();
      n_done = 0;
      mode_i = m;
      stall = st;
      src_clr = 1;
      @(negedge clock_i);
      src_clr = 0;
      exposure_trigger_i = 1;
      @(negedge clock_i);
      exposure_trigger_i = 0;
      chk("busy", 24'h1, {23'h0, busy_o});
      repeat (10) @(negedge clock_i);
      exposure_trigger_i = 1;
      @(negedge clock_i);
      exposure_trigger_i = 0;
      if (st) begin
         repeat (150) @(negedge clock_i);
         chk("full", 24'h0, {23'h0, pix_ready_o});
         chk("held", 24'h0, 24'(got.size()));
      end
      stall = 0;
      t = 0;
      while ((busy_o || got.size() < nb) && t < 4000) begin
         @(negedge clock_i);
         t++;
      end
      repeat (30) @(negedge clock_i);
      chk("idle", 24'h0, {23'h0, busy_o});
      chk("bytes", 24'(nb), 24'(got.size()));
      chk("frames", 24'(nd), 24'(n_done));
   endtask
   task automatic chk_pack(input int np);
      logic [11:0] e, o;
      for (int p = 0; p < np; p++) begin
         e = v(2 * p);
         o = v(2 * p + 1);
         chk("pack", {e[11:4], e[3:0], o[3:0], o[11:4]}, {got[3*p], got[3*p+1], got[3*p+2]});
      end
   endtask
   task automatic chk_sum(input int n, input int nb, input int nr);
      logic signed [23:0] s, c;
      logic hit;
      for (int r = 0; r < nr; r++) begin
         s = 0;
         c = 0;
         hit = 0;
         for (int i = 0; i < n; i++) begin
            s += $signed(v(n * r + i));
            // Whole sum takes the code of its first flagged sample
            if (!hit && bad(n * r + i)) begin
               c = $signed(v(n * r + i));
               hit = 1;
            end
         end
         if (hit)
            s = c;
         for (int b = 0; b < nb; b++)
            chk("sum", {16'h0000, s[8*(nb-1-b)+:8]}, {16'h0000, got[nb*r+b]});
      end
   endtask
   task automatic t_regs();
      rd(8'h02, 8'h34);
      rd(8'h05, 8'h3d);
      rd(8'h12, 8'h30);
      rd(8'h15, 8'h23);
      wr(8'h05, 8'h5a);
      rd(8'h05, 8'h5a);
      wr(8'h7f, 8'h11);
      rd(8'h7f, 8'h00);
      wr(8'h05, 8'h3d);
   endtask
   task automatic t_imager();
      flag_k = 8'd2;
      run(3'd0, 8'h00, 96, 1, 1'b1);
      chk_pack(32);
   endtask
   task automatic t_gray();
      run(3'd4, 8'h00, 96, 1, 1'b0);
      chk_pack(32);
      run(3'd5, 8'h00, 24, 1, 1'b0);
      chk_pack(8);
   endtask
   task automatic t_sums();
      flag_k = 8'd200;
      run(3'd1, 8'h10, 6, 2, 1'b0);
      chk_sum(64, 3, 2);
      run(3'd2, 8'h30, 32, 4, 1'b0);
      chk_sum(4, 2, 16);
      run(3'd3, 8'h10, 32, 2, 1'b0);
      chk_sum(8, 2, 16);
   endtask
   task automatic t_codes();
      flag_k = 8'd5;
      run(3'd2, 8'h00, 8, 1, 1'b0);
      chk_sum(4, 2, 4);
      wr(8'h15, 8'h63);
      raw_md = 1;
      run(3'd0, 8'h00, 96, 1, 1'b0);
      chk_pack(32);
      raw_md = 0;
      wr(8'h15, 8'h23);
   endtask
   initial begin
      {rstn_i, reg_wr_i, reg_rd_i, exposure_trigger_i, src_clr, stall, out_ready_i, raw_md} = '0;
      {reg_addr_i, reg_wdata_i, flag_k, mode_i} = '0;
      {failures, n_checks, cyc, n_done} = '0;
      repeat (4) @(posedge clock_i);
      @(negedge clock_i);
      rstn_i = 1;
      @(negedge clock_i);
      t_regs();
      t_imager();
      t_gray();
      t_sums();
      t_codes();
      conclude();
   end
endmodule // tb_tofms_top

/* File: dv/tofms_assertions.sv */
// Checker for the operating-mode select top ports
`timescale 1ns/10ps
module tofms_checker (
   input wire logic clock_i, // Clock
   input wire logic rstn_i, // Reset, low
   input wire logic reg_wr_i, // Write strobe
   input wire logic reg_rd_i, // Read strobe
   input wire logic [7:0] reg_addr_i, // Offset
   input wire logic [7:0] reg_wdata_i, // Write data
   input wire logic [7:0] reg_rdata_o, // Read data
   input wire logic exposure_trigger_i, // Trigger
   input wire logic busy_o, // Busy
   input wire logic pix_ready_o, // Sample ready
   input wire logic frame_done_o, // Frame pulse
   input wire logic out_valid_o, // Byte valid
   input wire logic out_ready_i, // Byte taken
   input wire logic [7:0] out_data_o // Byte
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   logic mapped;
   assign mapped = reg_addr_i inside {8'h02, 8'h05, 8'h12, 8'h15};
   AST_TRIG_BUSY: assert property (!busy_o && exposure_trigger_i |=> busy_o)
      else $error("trigger did not start acquisition");
   AST_TRIG_READY: assert property (!busy_o && exposure_trigger_i |=> pix_ready_o)
      else $error("no sample ready after trigger");
   AST_READY_BUSY: assert property (pix_ready_o |-> busy_o)
      else $error("sample ready while idle");
   AST_UNMAPPED: assert property (reg_rd_i && !mapped |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   AST_RD_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data moved without a read");
   AST_WR_RD: assert property (reg_wr_i && mapped ##1 reg_rd_i && !reg_wr_i &&
      reg_addr_i == $past(reg_addr_i) |=> reg_rdata_o == $past(reg_wdata_i, 2))
      else $error("register readback differs from write");
   AST_DONE_PULSE: assert property (frame_done_o |=> !frame_done_o)
      else $error("frame done longer than one cycle");
   AST_OUT_HOLD: assert property (out_valid_o && !out_ready_i |=>
      out_valid_o && $stable(out_data_o))
      else $error("output byte dropped under stall");
endmodule // tofms_checker
bind tofms_top tofms_checker u_chk (.clock_i, .rstn_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
   .reg_wdata_i, .reg_rdata_o, .exposure_trigger_i, .busy_o, .pix_ready_o, .frame_done_o,
   .out_valid_o, .out_ready_i, .out_data_o);

/* File: dv/tofms_pixel_src.sv */
// Pixel sample source standing in for the array front end
`timescale 1ns/10ps
module tofms_pixel_src (
   input wire logic clock_i, // System clock
   input wire logic rstn_i, // Reset, low
   input wire logic clr_i, // Restart sample sequence
   input wire logic [7:0] flag_k_i, // First flagged sample index
   input wire logic pix_ready_i, // Sample taken
   output logic pix_valid_o, // Sample offered
   output logic [11:0] pix_data_o, // Sample value
   output logic pix_sat_o, // Saturated
   output logic pix_ovf_o, // Overflow
   output logic pix_unf_o // Underflow
);
   logic [7:0] k_r;
   logic [11:0] raw;
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i)
         k_r <= 8'h00;
      else if (clr_i)
         k_r <= 8'h00;
      else if (pix_valid_o && pix_ready_i)
         k_r <= k_r + 8'h01;
   end
   assign raw = 12'(37 * k_r + 5);
   assign pix_valid_o = rstn_i && !clr_i;
   // Idle data inverted so a stale sample cannot pass
   assign pix_data_o = pix_valid_o ? raw : ~raw;
   assign pix_sat_o = pix_valid_o && k_r == flag_k_i;
   assign pix_ovf_o = pix_valid_o && k_r == flag_k_i + 8'h01;
   assign pix_unf_o = pix_valid_o && k_r == flag_k_i + 8'h05;
endmodule // tofms_pixel_src

/* File: verilog/tofms_defines.svh */
// Constants for the time-of-flight operating-mode select block
`ifndef TOFMS_DEFINES_SVH
`define TOFMS_DEFINES_SVH
`define TOFMS_OFS_PH1 8'h02
`define TOFMS_OFS_PH2 8'h05
`define TOFMS_OFS_MOD 8'h12
`define TOFMS_OFS_RDM 8'h15
`define TOFMS_RST_PH1 8'h34
`define TOFMS_RST_PH2 8'h3d
`define TOFMS_RST_MOD 8'h30
`define TOFMS_RST_RDM 8'h23
`define TOFMS_MOD_4PH 8'h30
`define TOFMS_MOD_2PH 8'h10
`define TOFMS_RDM_RAW_BIT 6
`define TOFMS_CODE_SAT 12'h7ff
`define TOFMS_CODE_OVF 12'h7fe
`define TOFMS_CODE_UNF 12'h800
`define TOFMS_PIX_FULL 7'h40
`define TOFMS_PIX_BIN 7'h10
`define TOFMS_GRP_PAIR 7'h02
`define TOFMS_GRP_ULN 7'h40
`define TOFMS_GRP_UFS 7'h04
`define TOFMS_GRP_UHD 7'h08
`define TOFMS_PH_4 3'h4
`define TOFMS_PH_2 3'h2
`define TOFMS_PH_1 3'h1
`define TOFMS_BYTES_3 2'h3
`define TOFMS_BYTES_2 2'h2
`define TOFMS_FIFO_W 8
`define TOFMS_FIFO_D 16
`endif

/* File: verilog/tofms_fifo.sv */
// Output byte FIFO with registered read stage
`timescale 1ns/10ps
module tofms_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input wire logic clock_i, // System clock
   input wire logic rstn_i, // Async reset, low
   input wire logic in_valid_i, // Write request
   output logic in_ready_o, // Space available
   input wire logic [W-1:0] in_data_i, // Write data
   output logic out_valid_o, // Read data valid
   input wire logic out_ready_i, // Reader takes data
   output logic [W-1:0] out_data_o // Read data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_r [D];
   logic [W-1:0] mem_nxt [D];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic ov_r, ov_nxt;
   logic [W-1:0] od_r, od_nxt;
   logic wr, rd;

   always_comb begin
      wr = in_valid_i && (cnt_r != D[AW:0]);
      rd = (cnt_r != '0) && (!ov_r || out_ready_i);
      wp_nxt = wr ? wp_r + 1'b1 : wp_r;
      rp_nxt = rd ? rp_r + 1'b1 : rp_r;
      cnt_nxt = cnt_r + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
      ov_nxt = rd ? 1'b1 : (out_ready_i ? 1'b0 : ov_r);
      od_nxt = rd ? mem_r[rp_r] : od_r;
   end

   genvar i;
   generate
      for (i = 0; i < D; i++) begin : g_mem
         always_comb begin
            mem_nxt[i] = (wr && wp_r == AW'(i)) ? in_data_i : mem_r[i];
         end
         always_ff @(posedge clock_i or negedge rstn_i) begin
            if (!rstn_i) begin
               mem_r[i] <= '0;
            end else begin
               mem_r[i] <= mem_nxt[i];
            end
         end
      end
   endgenerate

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         ov_r <= 1'b0;
         od_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
         ov_r <= ov_nxt;
         od_r <= od_nxt;
      end
   end

   assign in_ready_o = (cnt_r != D[AW:0]);
   assign out_valid_o = ov_r;
   assign out_data_o = od_r;
endmodule // tofms_fifo

/* File: verilog/tofms_pkg.sv */
// Types for the time-of-flight operating-mode select block
package tofms_pkg;
   typedef enum logic [2:0] {
      phase_imager_mode,
      low_noise_rangefinder_mode,
      fast_rangefinder_mode,
      high_dynamic_rangefinder_mode,
      gray_imager_mode,
      gray_binned_imager_mode
   } tofms_mode_t;
   typedef enum logic {tofms_idle, tofms_acquire} tofms_state_t;
endpackage

/* File: verilog/tofms_top.sv */
// Operating-mode select, summing and readout packing for the 8x8 ToF array
`timescale 1ns/10ps
`include "tofms_defines.svh"
module tofms_top (
   input wire logic clock_i, // 125 MHz system clock
   input wire logic rstn_i, // Async reset, low
   input wire logic reg_wr_i, // Register write strobe
   input wire logic reg_rd_i, // Register read strobe
   input wire logic [7:0] reg_addr_i, // Register offset
   input wire logic [7:0] reg_wdata_i, // Register write data
   output logic [7:0] reg_rdata_o, // Register read data
   input wire logic [2:0] mode_i, // Operating mode select
   input wire logic exposure_trigger_i, // Start acquisition pulse
   input wire logic pix_valid_i, // Pixel sample valid
   output logic pix_ready_o, // Pixel sample accepted
   input wire logic [11:0] pix_data_i, // Signed pixel sample
   input wire logic pix_sat_i, // Pixel saturated
   input wire logic pix_ovf_i, // Converter overflow
   input wire logic pix_unf_i, // Converter underflow
   output logic busy_o, // Acquisition running
   output logic frame_done_o, // Phase frame complete pulse
   output logic out_valid_o, // Output byte valid
   input wire logic out_ready_i, // Output byte taken
   output logic [7:0] out_data_o // Output byte
);
   tofms_pkg::tofms_state_t st_r, st_nxt;
   tofms_pkg::tofms_mode_t mode_r, mode_nxt;
   logic [7:0] ph1_r, ph1_nxt, ph2_r, ph2_nxt, mod_r, mod_nxt, rdm_r, rdm_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [2:0] frames_r, frames_nxt;
   logic [6:0] smp_r, smp_nxt, grp_r, grp_nxt;
   logic [17:0] acc_r, acc_nxt;
   logic [11:0] flag_r, flag_nxt, first_r, first_nxt;
   logic flagged_r, flagged_nxt;
   logic [23:0] sh_r, sh_nxt;
   logic [1:0] bytes_r, bytes_nxt;
   logic ready_r, ready_nxt, busy_r, busy_nxt, done_r, done_nxt;
   logic take, fifo_ready, embed, pack, inval, last_grp;
   logic [6:0] grp_n, frame_n;
   logic [11:0] code, samp;
   logic [17:0] sum;

   // Register file
   always_comb begin
      ph1_nxt = ph1_r;
      ph2_nxt = ph2_r;
      mod_nxt = mod_r;
      rdm_nxt = rdm_r;
      rdata_nxt = rdata_r;
      if (reg_wr_i) begin
         case (reg_addr_i)
            `TOFMS_OFS_PH1: ph1_nxt = reg_wdata_i;
            `TOFMS_OFS_PH2: ph2_nxt = reg_wdata_i;
            `TOFMS_OFS_MOD: mod_nxt = reg_wdata_i;
            `TOFMS_OFS_RDM: rdm_nxt = reg_wdata_i;
            default: ;
         endcase
      end
      if (reg_rd_i) begin
         case (reg_addr_i)
            `TOFMS_OFS_PH1: rdata_nxt = ph1_r;
            `TOFMS_OFS_PH2: rdata_nxt = ph2_r;
            `TOFMS_OFS_MOD: rdata_nxt = mod_r;
            `TOFMS_OFS_RDM: rdata_nxt = rdm_r;
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   // Per-mode group size and frame length
   always_comb begin
      pack = 1'b0;
      grp_n = `TOFMS_GRP_PAIR;
      frame_n = `TOFMS_PIX_FULL;
      case (mode_r)
         tofms_pkg::phase_imager_mode: pack = 1'b1;
         tofms_pkg::gray_imager_mode: pack = 1'b1;
         tofms_pkg::gray_binned_imager_mode: begin
            pack = 1'b1;
            frame_n = `TOFMS_PIX_BIN;
         end
         tofms_pkg::low_noise_rangefinder_mode: grp_n = `TOFMS_GRP_ULN;
         tofms_pkg::fast_rangefinder_mode: begin
            grp_n = `TOFMS_GRP_UFS;
            frame_n = `TOFMS_PIX_BIN;
         end
         tofms_pkg::high_dynamic_rangefinder_mode: grp_n = `TOFMS_GRP_UHD;
         default: pack = 1'b1;
      endcase
   end

   // Invalid code substitution, saturation has priority
   always_comb begin
      embed = !rdm_r[`TOFMS_RDM_RAW_BIT];
      inval = embed && (pix_sat_i || pix_ovf_i || pix_unf_i);
      code = pix_sat_i ? `TOFMS_CODE_SAT : (pix_ovf_i ? `TOFMS_CODE_OVF : `TOFMS_CODE_UNF);
      samp = inval ? code : pix_data_i;
   end

   // Acquisition, summing and packing
   always_comb begin
      take = pix_valid_i && ready_r;
      st_nxt = st_r;
      mode_nxt = mode_r;
      frames_nxt = frames_r;
      smp_nxt = smp_r;
      grp_nxt = grp_r;
      acc_nxt = acc_r;
      flag_nxt = flag_r;
      flagged_nxt = flagged_r;
      first_nxt = first_r;
      sh_nxt = sh_r;
      bytes_nxt = bytes_r;
      done_nxt = 1'b0;
      last_grp = (grp_r == grp_n - 7'h01);
      sum = ((grp_r == 7'h00) ? 18'h00000 : acc_r) + {{6{pix_data_i[11]}}, pix_data_i};
      if (bytes_r != 2'h0 && fifo_ready) begin
         sh_nxt = {sh_r[15:0], 8'h00};
         bytes_nxt = bytes_r - 2'h1;
      end
      case (st_r)
         tofms_pkg::tofms_idle: begin
            if (exposure_trigger_i) begin
               st_nxt = tofms_pkg::tofms_acquire;
               mode_nxt = tofms_pkg::tofms_mode_t'(mode_i);
               smp_nxt = 7'h00;
               grp_nxt = 7'h00;
               if (mod_r == `TOFMS_MOD_4PH) begin
                  frames_nxt = `TOFMS_PH_4;
               end else if (mod_r == `TOFMS_MOD_2PH) begin
                  frames_nxt = `TOFMS_PH_2;
               end else begin
                  frames_nxt = `TOFMS_PH_1;
               end
            end
         end
         tofms_pkg::tofms_acquire: begin
            if (take) begin
               grp_nxt = last_grp ? 7'h00 : grp_r + 7'h01;
               if (pack) begin
                  if (grp_r == 7'h00) begin
                     first_nxt = samp;
                  end else begin
                     // Even high, mixed nibbles, odd high
                     sh_nxt = {first_r[11:4], first_r[3:0], samp[3:0], samp[11:4]};
                     bytes_nxt = `TOFMS_BYTES_3;
                  end
               end else begin
                  acc_nxt = sum;
                  // First flagged pixel of a sum names the code
                  flagged_nxt = (grp_r == 7'h00) ? inval : (flagged_r || inval);
                  flag_nxt = (grp_r == 7'h00 || !flagged_r) ? code : flag_r;
                  if (last_grp) begin
                     if (flagged_nxt) begin
                        sh_nxt = {{12{flag_nxt[11]}}, flag_nxt};
                        sh_nxt = {sh_nxt[15:0], 8'h00};
                     end else begin
                        sh_nxt = {sum[15:0], 8'h00};
                     end
                     bytes_nxt = `TOFMS_BYTES_2;
                     if (mode_r == tofms_pkg::low_noise_rangefinder_mode) begin
                        sh_nxt = flagged_nxt ? {{12{flag_nxt[11]}}, flag_nxt}
                                             : {{6{sum[17]}}, sum};
                        bytes_nxt = `TOFMS_BYTES_3;
                     end
                  end
               end
               if (smp_r == frame_n - 7'h01) begin
                  smp_nxt = 7'h00;
                  done_nxt = 1'b1;
                  frames_nxt = frames_r - 3'h1;
                  if (frames_r == `TOFMS_PH_1) begin
                     st_nxt = tofms_pkg::tofms_idle;
                  end
               end else begin
                  smp_nxt = smp_r + 7'h01;
               end
            end
         end
         default: st_nxt = tofms_pkg::tofms_idle;
      endcase
      // Hold input off while a result still drains into the FIFO
      ready_nxt = (st_nxt == tofms_pkg::tofms_acquire) && (bytes_nxt == 2'h0);
      busy_nxt = (st_nxt == tofms_pkg::tofms_acquire);
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ph1_r <= `TOFMS_RST_PH1;
         ph2_r <= `TOFMS_RST_PH2;
         mod_r <= `TOFMS_RST_MOD;
         rdm_r <= `TOFMS_RST_RDM;
         rdata_r <= 8'h00;
         st_r <= tofms_pkg::tofms_idle;
         mode_r <= tofms_pkg::phase_imager_mode;
         frames_r <= 3'h0;
         smp_r <= 7'h00;
         grp_r <= 7'h00;
         acc_r <= 18'h00000;
         flag_r <= 12'h000;
         flagged_r <= 1'b0;
         first_r <= 12'h000;
         sh_r <= 24'h000000;
         bytes_r <= 2'h0;
         ready_r <= 1'b0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         ph1_r <= ph1_nxt;
         ph2_r <= ph2_nxt;
         mod_r <= mod_nxt;
         rdm_r <= rdm_nxt;
         rdata_r <= rdata_nxt;
         st_r <= st_nxt;
         mode_r <= mode_nxt;
         frames_r <= frames_nxt;
         smp_r <= smp_nxt;
         grp_r <= grp_nxt;
         acc_r <= acc_nxt;
         flag_r <= flag_nxt;
         flagged_r <= flagged_nxt;
         first_r <= first_nxt;
         sh_r <= sh_nxt;
         bytes_r <= bytes_nxt;
         ready_r <= ready_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
      end
   end

   tofms_fifo #(
      .W(`TOFMS_FIFO_W),
      .D(`TOFMS_FIFO_D)
   ) u_fifo (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .in_valid_i(bytes_r != 2'h0),
      .in_ready_o(fifo_ready),
      .in_data_i(sh_r[23:16]),
      .out_valid_o(out_valid_o),
      .out_ready_i(out_ready_i),
      .out_data_o(out_data_o)
   );

   assign reg_rdata_o = rdata_r;
   assign pix_ready_o = ready_r;
   assign busy_o = busy_r;
   assign frame_done_o = done_r;
endmodule // tofms_top
